// File: design/bma_regs.svh
// bma_regs.svh: bus-state numbers and pin widths for the bus mastership arbiter.
// Assumes one bus state per ref_clk period; included by bare name.
`ifndef BMA_REGS_SVH
`define BMA_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BMA_ADDR_W 23
`define BMA_DATA_W 16
`define BMA_STEP_W 5

// ----------------------------------------------------------------
// bus state numbers
// ----------------------------------------------------------------
`define BMA_ST_FIRST 5'h00
`define BMA_ST_STROBE_ON 5'h02
`define BMA_ST_WR_DATA 5'h03
`define BMA_ST_WR_STROBE 5'h04
`define BMA_ST_ACK_READ 5'h04
`define BMA_ST_LATCH 5'h07
`define BMA_ST_RD_END 5'h07
`define BMA_ST_QUIET 5'h09
`define BMA_ST_RMW_DIR 5'h0E
`define BMA_ST_RMW_DATA 5'h0F
`define BMA_ST_RMW_STROBE 5'h10
`define BMA_ST_RMW_END 5'h13

`endif

// File: design/bma_pkg.sv
// bma_pkg: state types of the bus mastership arbiter.
// Assumes the constants of bma_regs.svh for all numbers.
package bma_pkg;

  typedef enum logic [2:0] {
    BMA_BUS_IDLE,
    BMA_BUS_RUN,
    BMA_BUS_FAULT,
    BMA_BUS_HALT
  } bma_bus_t;

  typedef enum logic [1:0] {
    BMA_ARB_IDLE,
    BMA_ARB_OFFER,
    BMA_ARB_OWNED
  } bma_arb_t;

endpackage

// File: design/bma_sync.sv
// bma_sync: two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to ref_clk; the first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none

module bma_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] stage1;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= INIT;
      level <= INIT;
    end else begin
      stage1 <= pin;
      level <= stage1;
    end
  end

endmodule

`default_nettype wire

// File: design/bma_arbiter.sv
// bma_arbiter: bus cycle sequencer with mastership arbitration and bus fault entry.
// Assumes a 10 MHz ref_clk, one bus state per clock, pins outside the clock domain.
//
// Summary of operation
// - direction high on read, low at state 14
// - data undriven state 14, driven from 15
// - no control output changes in state 9
// - byte strobe at 16; slave stores, acknowledges
// - no ack by 16 end: wait states inserted
// - state 19 drops strobes, holds address/data/direction
// - data bus released after state 19
// - requests handled while transfers run
// - bus released only after started cycle
// - request dropped before taken: resume processing
// - grant after sync; delayed past committed strobe
// - grant drops on taken; reoffered if pending
// - every asynchronous control input synchronised before use; data_in sampled directly
// - arbitration updates on edge after sync
// - float control tristates buses once strobe negated
// - bus fault: exception or retry cycle
// - address strobe held states 2 to 18 of rmw cycle
// - fault with halt: re-run sequence
// - rmw cycle never re-run; fault handled
`timescale 1ns/100ps
`default_nettype none

`include "bma_regs.svh"

module bma_arbiter
  import bma_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // core cycle requests
  input wire logic cycle_req,
  input wire logic cycle_write,
  input wire logic cycle_rmw,
  input wire logic [`BMA_ADDR_W-1:0] cycle_addr,
  input wire logic [`BMA_DATA_W-1:0] cycle_wdata,
  input wire logic [1:0] cycle_bsel,
  input wire logic [2:0] cycle_space,
  output logic cycle_ready,
  output logic cycle_done,
  output logic [`BMA_DATA_W-1:0] cycle_rdata,
  output logic fault_exception,
  output logic bus_floated,
  // arbitration pins
  input wire logic mastership_request_n,
  output logic mastership_grant_n,
  input wire logic mastership_taken_n,
  // bus pins
  output logic address_valid_strobe_n,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic direction,
  output logic [2:0] space_code,
  output logic [`BMA_ADDR_W-1:0] address,
  output logic bus_oe,
  output logic [`BMA_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [`BMA_DATA_W-1:0] data_in,
  input wire logic transfer_ack_n,
  input wire logic bus_fault_in_n,
  input wire logic halt_in_n
);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bma_bus_t bus;
    logic [`BMA_STEP_W-1:0] step;
    logic rmw;
    logic wr;
    logic faulted;
    logic [`BMA_ADDR_W-1:0] addr;
    logic [`BMA_DATA_W-1:0] wdata;
    logic [1:0] bsel;
    logic [2:0] space;
    logic [`BMA_DATA_W-1:0] rdata;
    logic ready;
    logic done;
    logic fault_exc;
    bma_arb_t arb;
    logic taken_prev;
    logic grant_n;
    logic as_n;
    logic uds_n;
    logic lds_n;
    logic dir;
    logic bus_oe;
    logic data_oe;
    logic floated;
  } bma_state_t;

  bma_state_t q, next_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // the two-flop stage adds two clocks of latency before a pin level is used
  logic [4:0] pins_s;
  logic req, tkn, ack, flt, hlt;

  bma_sync #(.W(5), .INIT(5'h1F)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin({mastership_request_n, mastership_taken_n, transfer_ack_n, bus_fault_in_n, halt_in_n}),
    .level(pins_s)
  );

  // active-low pins turned to positive logic after the sync stage
  assign req = ~pins_s[4];
  assign tkn = ~pins_s[3];
  assign ack = ~pins_s[2];
  assign flt = ~pins_s[1];
  assign hlt = ~pins_s[0];

  function automatic logic in_range(input logic [`BMA_STEP_W-1:0] s, input logic [`BMA_STEP_W-1:0] lo,
                                    input logic [`BMA_STEP_W-1:0] hi);
    in_range = (s >= lo) && (s <= hi);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic start, hold_grant, flt_float;
  logic [`BMA_STEP_W-1:0] ns;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    next_q.fault_exc = 1'b0;
    next_q.taken_prev = tkn;
    ns = q.step;
    start = cycle_req && q.ready;
    // committed to a cycle whose strobe is not yet out: grant waits
    hold_grant = start || (q.bus == BMA_BUS_RUN && q.step < `BMA_ST_STROBE_ON);
    flt_float = 1'b0;

    // arbitration runs beside the bus cycle, not after it
    case (q.arb)
      BMA_ARB_IDLE: begin
        if (req && !hold_grant) begin
          next_q.arb = BMA_ARB_OFFER;
          next_q.grant_n = 1'b0;
        end
      end
      BMA_ARB_OFFER: begin
        if (tkn && !q.taken_prev) begin
          next_q.arb = BMA_ARB_OWNED;
          next_q.grant_n = 1'b1;
        end else if (!req && !tkn) begin
          // spurious request: back to normal processing
          next_q.arb = BMA_ARB_IDLE;
          next_q.grant_n = 1'b1;
        end
      end
      default: begin
        if (!tkn) begin
          next_q.arb = BMA_ARB_IDLE;
        end else if (req) begin
          next_q.arb = BMA_ARB_OFFER;
          next_q.grant_n = 1'b0;
        end
      end
    endcase

    case (q.bus)
      BMA_BUS_IDLE: begin
        if (start) begin
          next_q.bus = BMA_BUS_RUN;
          ns = `BMA_ST_FIRST;
          next_q.rmw = cycle_rmw;
          next_q.wr = cycle_write && !cycle_rmw;
          next_q.faulted = 1'b0;
          next_q.addr = cycle_addr;
          next_q.wdata = cycle_wdata;
          next_q.bsel = cycle_bsel;
          next_q.space = cycle_space;
        end
      end
      BMA_BUS_RUN: begin
        ns = q.step + 5'h01;
        if (q.step == `BMA_ST_ACK_READ || (q.rmw && q.step == `BMA_ST_RMW_STROBE)) begin
          if (flt) begin
            // a fault ends the cycle, rmw included
            next_q.faulted = 1'b1;
            ns = `BMA_ST_RD_END;
          end else if (!ack) begin
            ns = q.step;
          end
        end
        if (q.step == 5'h06 && !q.wr) begin
          next_q.rdata = data_in;
        end
        if ((q.step == `BMA_ST_RD_END && (!q.rmw || q.faulted)) || q.step == `BMA_ST_RMW_END) begin
          next_q.bus = q.faulted ? BMA_BUS_FAULT : BMA_BUS_IDLE;
          next_q.done = !q.faulted;
          ns = `BMA_ST_FIRST;
        end
      end
      BMA_BUS_FAULT: begin
        flt_float = 1'b1;
        if (!flt) begin
          if (hlt && !q.rmw) begin
            next_q.bus = BMA_BUS_HALT;
          end else begin
            next_q.bus = BMA_BUS_IDLE;
            next_q.fault_exc = 1'b1;
          end
        end
      end
      default: begin
        flt_float = 1'b1;
        // re-run the same cycle with the same address, codes and data
        if (!hlt) begin
          next_q.bus = BMA_BUS_RUN;
          next_q.faulted = 1'b0;
          ns = `BMA_ST_FIRST;
        end
      end
    endcase
    next_q.step = ns;

    // pin levels for the state being entered
    if (next_q.bus == BMA_BUS_RUN) begin
      next_q.as_n = !(in_range(ns, `BMA_ST_STROBE_ON, 5'h06) ||
                      (next_q.rmw && !next_q.faulted && in_range(ns, `BMA_ST_STROBE_ON, 5'h12)));
      next_q.uds_n = !(next_q.bsel[1] && ((!next_q.wr && in_range(ns, `BMA_ST_STROBE_ON, 5'h06)) ||
                                          (next_q.wr && in_range(ns, `BMA_ST_WR_STROBE, 5'h06)) ||
                                          (next_q.rmw && in_range(ns, `BMA_ST_RMW_STROBE, 5'h12))));
      next_q.lds_n = !(next_q.bsel[0] && ((!next_q.wr && in_range(ns, `BMA_ST_STROBE_ON, 5'h06)) ||
                                          (next_q.wr && in_range(ns, `BMA_ST_WR_STROBE, 5'h06)) ||
                                          (next_q.rmw && in_range(ns, `BMA_ST_RMW_STROBE, 5'h12))));
      next_q.dir = !((next_q.wr && ns >= `BMA_ST_STROBE_ON) || (next_q.rmw && ns >= `BMA_ST_RMW_DIR));
      next_q.data_oe = (next_q.wr && in_range(ns, `BMA_ST_WR_DATA, `BMA_ST_RD_END)) ||
                       (next_q.rmw && in_range(ns, `BMA_ST_RMW_DATA, `BMA_ST_RMW_END));
      next_q.bus_oe = 1'b1;
    end else begin
      next_q.as_n = 1'b1;
      next_q.uds_n = 1'b1;
      next_q.lds_n = 1'b1;
      next_q.dir = 1'b1;
      next_q.data_oe = 1'b0;
      // float control: bus given away or fault pending, strobe already negated
      next_q.bus_oe = !(flt_float || next_q.bus != BMA_BUS_IDLE || next_q.arb != BMA_ARB_IDLE || tkn);
    end
    next_q.ready = next_q.bus == BMA_BUS_IDLE && next_q.arb == BMA_ARB_IDLE && !tkn && !req;
    next_q.floated = !next_q.bus_oe;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{bus: BMA_BUS_IDLE, step: `BMA_ST_FIRST, arb: BMA_ARB_IDLE, grant_n: 1'b1, as_n: 1'b1,
             uds_n: 1'b1, lds_n: 1'b1, dir: 1'b1, bus_oe: 1'b1, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cycle_ready = q.ready;
  assign cycle_done = q.done;
  assign cycle_rdata = q.rdata;
  assign fault_exception = q.fault_exc;
  assign bus_floated = q.floated;
  assign mastership_grant_n = q.grant_n;
  assign address_valid_strobe_n = q.as_n;
  assign upper_byte_strobe_n = q.uds_n;
  assign lower_byte_strobe_n = q.lds_n;
  assign direction = q.dir;
  assign space_code = q.space;
  assign address = q.addr;
  assign bus_oe = q.bus_oe;
  assign data_out = q.wdata;
  assign data_oe = q.data_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic rmw_run;
  assign rmw_run = q.bus == BMA_BUS_RUN && q.rmw && !q.faulted;

  property p_rmw_dir;
    rmw_run && q.step == `BMA_ST_RMW_DIR |-> !direction && $past(direction);
  endproperty
  a_rmw_dir: assert property (p_rmw_dir) else $error("direction not lowered at state 14");
  property p_rmw_turn;
    rmw_run && q.step == `BMA_ST_RMW_DIR |-> !data_oe ##1 data_oe;
  endproperty
  a_rmw_turn: assert property (p_rmw_turn) else $error("data turnaround wrong");
  property p_quiet;
    rmw_run && q.step == `BMA_ST_QUIET |-> $stable({address_valid_strobe_n, upper_byte_strobe_n,
                                                    lower_byte_strobe_n, direction, data_oe});
  endproperty
  a_quiet: assert property (p_quiet) else $error("control changed in state 9");
  property p_wstrobe;
    rmw_run && q.step == `BMA_ST_RMW_STROBE |-> !(upper_byte_strobe_n && lower_byte_strobe_n) && data_oe;
  endproperty
  a_wstrobe: assert property (p_wstrobe) else $error("no byte strobe at state 16");
  property p_wait;
    rmw_run && q.step == `BMA_ST_RMW_STROBE && !ack && !flt |=> q.step == `BMA_ST_RMW_STROBE;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state missing");
  property p_end;
    rmw_run && q.step == `BMA_ST_RMW_END |-> address_valid_strobe_n && upper_byte_strobe_n &&
                                               lower_byte_strobe_n && !direction && data_oe ##1 !data_oe;
  endproperty
  a_end: assert property (p_end) else $error("state 19 levels wrong");
  property p_as_held;
    rmw_run && q.step >= `BMA_ST_STROBE_ON && q.step < `BMA_ST_RMW_END |-> !address_valid_strobe_n;
  endproperty
  a_as_held: assert property (p_as_held) else $error("strobe dropped inside rmw");
  property p_grant;
    q.arb == BMA_ARB_IDLE && req && !hold_grant |=> !mastership_grant_n;
  endproperty
  a_grant: assert property (p_grant) else $error("grant not given");
  // the reoffer decision is made on the request and taken levels of the cycle before
  property p_regrant;
    q.arb == BMA_ARB_OFFER && tkn && !q.taken_prev |=> mastership_grant_n ##1
      (!$past(req) || !$past(tkn) || !mastership_grant_n);
  endproperty
  a_regrant: assert property (p_regrant) else $error("grant handling after taken wrong");
  property p_no_rerun;
    q.bus == BMA_BUS_FAULT && q.rmw && !flt |=> fault_exception && q.bus == BMA_BUS_IDLE;
  endproperty
  a_no_rerun: assert property (p_no_rerun) else $error("rmw cycle re-run");

endmodule

`default_nettype wire

// File: verif/bma_slave.sv
// bma_slave: far-side slave that answers arbiter bus cycles with acknowledge or bus fault.
// Assumes the arbiter changes strobes on ref_clk rising edges; the bench picks delay and fault.
`timescale 1ns/100ps
`default_nettype none

`include "bma_regs.svh"

module bma_slave (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // bus seen from the arbiter
  input wire logic address_valid_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic direction,
  input wire logic [`BMA_DATA_W-1:0] data_out,
  // behaviour chosen by the bench
  input wire logic [3:0] ack_delay,
  input wire logic fault_mode,
  input wire logic [`BMA_DATA_W-1:0] rd_word,
  // answers
  output logic transfer_ack_n,
  output logic bus_fault_in_n,
  output logic [`BMA_DATA_W-1:0] data_in,
  output logic [`BMA_DATA_W-1:0] stored
);
  logic [3:0] cnt;
  logic sel;

  assign sel = !address_valid_strobe_n && !(upper_byte_strobe_n && lower_byte_strobe_n);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      transfer_ack_n <= 1'b1;
      bus_fault_in_n <= 1'b1;
      data_in <= 16'hA5C3;
      stored <= 16'h0000;
    end else if (!sel) begin
      // released data never holds its last value
      cnt <= 4'h0;
      transfer_ack_n <= 1'b1;
      bus_fault_in_n <= 1'b1;
      data_in <= ~data_in;
    end else begin
      cnt <= cnt + 4'h1;
      if (direction) begin
        data_in <= rd_word;
      end
      if (cnt == ack_delay && fault_mode) begin
        bus_fault_in_n <= 1'b0;
      end else if (cnt == ack_delay) begin
        transfer_ack_n <= 1'b0;
        if (!direction) begin
          stored <= data_out;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/bus_mastership_arbitration_bench.sv
// bus_mastership_arbitration_bench: random and corner bus cycles, arbitration and faults.
// Assumes bma_slave as the only slave; inputs change on falling edges of ref_clk.
`timescale 1ns/100ps
`default_nettype none

`include "bma_regs.svh"

module bus_mastership_arbitration_bench;
  logic ref_clk, reset_n, cycle_req, cycle_write, cycle_rmw, cycle_ready, cycle_done;
  logic fault_exception, bus_floated, fault_mode, halt_in_n, transfer_ack_n, bus_fault_in_n;
  logic mastership_request_n, mastership_grant_n, mastership_taken_n, direction, bus_oe, data_oe;
  logic address_valid_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n;
  logic [`BMA_ADDR_W-1:0] cycle_addr, address;
  logic [`BMA_DATA_W-1:0] cycle_wdata, cycle_rdata, data_out, data_in, rd_word, stored;
  logic [1:0] cycle_bsel;
  logic [2:0] cycle_space, space_code;
  logic [3:0] ack_delay;
  int n_errors, checked, n, k, i;

  bma_arbiter u_dut (.ref_clk, .reset_n, .cycle_req, .cycle_write, .cycle_rmw, .cycle_addr,
    .cycle_wdata, .cycle_bsel, .cycle_space, .cycle_ready, .cycle_done, .cycle_rdata,
    .fault_exception, .bus_floated, .mastership_request_n, .mastership_grant_n,
    .mastership_taken_n, .address_valid_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n,
    .direction, .space_code, .address, .bus_oe, .data_out, .data_oe, .data_in,
    .transfer_ack_n, .bus_fault_in_n, .halt_in_n);

  bma_slave u_slave (.ref_clk, .reset_n, .address_valid_strobe_n, .upper_byte_strobe_n,
    .lower_byte_strobe_n, .direction, .data_out, .ack_delay, .fault_mode, .rd_word,
    .transfer_ack_n, .bus_fault_in_n, .data_in, .stored);

  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("counts: checked %0d, n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task wait_grant(input logic lvl);
    k = 0;
    while (mastership_grant_n !== lvl && k < 12) begin
      @(negedge ref_clk);
      k++;
    end
    chk(mastership_grant_n, lvl);
  endtask

  // one core cycle; watches the pins each cycle and returns its length in len
  task run(input logic wr, input logic rmw, input logic [1:0] bsel, output int len);
    int as_on, st_on, t_dir, t_oe;
    logic pas, pst, pdir, poe, st;
    logic [`BMA_DATA_W-1:0] m;
    as_on = 0;
    st_on = 0;
    t_dir = 0;
    t_oe = 0;
    len = 0;
    {pas, pst, pdir, poe} = 4'hE;
    m = {{8{bsel[1]}}, {8{bsel[0]}}};
    cycle_addr = `BMA_ADDR_W'($urandom);
    cycle_wdata = 16'($urandom);
    cycle_space = 3'($urandom);
    rd_word = 16'($urandom);
    {cycle_write, cycle_rmw, cycle_bsel} = {wr, rmw, bsel};
    while (cycle_ready !== 1'b1 && len < 60) begin
      @(negedge ref_clk);
      len++;
    end
    cycle_req = 1'b1;
    @(negedge ref_clk);
    cycle_req = 1'b0;
    len = 1;
    while (cycle_done !== 1'b1 && fault_exception !== 1'b1 && len < 300) begin
      st = upper_byte_strobe_n & lower_byte_strobe_n;
      if (pas && !address_valid_strobe_n) as_on++;
      if (pst && !st) st_on++;
      if (pdir && !direction) t_dir = len;
      if (!poe && data_oe) t_oe = len;
      if (!pas && address_valid_strobe_n && !fault_mode && (wr || rmw)) chk({direction, data_oe}, 2'b01);
      if (!pas && address_valid_strobe_n) chk({space_code, address}, {cycle_space, cycle_addr});
      if (pst && !st) chk({upper_byte_strobe_n, lower_byte_strobe_n}, {~bsel[1], ~bsel[0]});
      {pas, pst, pdir, poe} = {address_valid_strobe_n, st, direction, data_oe};
      @(negedge ref_clk);
      len++;
    end
    chk({cycle_done, fault_exception}, fault_mode ? 2'b01 : 2'b10);
    if (!fault_mode) begin
      chk(data_oe, 1'b0);
      if (!wr || rmw) chk(cycle_rdata & m, rd_word & m);
      if (wr || rmw) chk(stored & m, cycle_wdata & m);
      if (wr || rmw) chk(t_oe, t_dir + 1);
      if (rmw) chk({as_on[3:0], st_on[3:0]}, 8'h12);
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----
  // watchdog
  // ----
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    conclude;
  end

  initial begin
    {n_errors, checked} = 0;
    {reset_n, cycle_req, cycle_write, cycle_rmw, fault_mode} = 5'h00;
    {mastership_request_n, mastership_taken_n, halt_in_n} = 3'h7;
    {cycle_addr, cycle_wdata, rd_word, cycle_bsel, cycle_space, ack_delay} = '0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    void'($urandom(95));
    for (i = 0; i < 12; i++) begin
      ack_delay = 4'($urandom_range(3, 0));
      run(1'($urandom), i > 9, (i > 9) ? 2'(i - 9) : 2'($urandom_range(3, 1)), n);
    end
    $display("test: random and rmw cycles ended");
    ack_delay = 4'h2;
    run(1'b0, 1'b0, 2'b11, k);
    ack_delay = 4'h5;
    run(1'b0, 1'b0, 2'b11, n);
    chk(n - k, 3);
    ack_delay = 4'h2;
    run(1'b0, 1'b1, 2'b01, k);
    ack_delay = 4'h5;
    run(1'b0, 1'b1, 2'b01, n);
    chk(n - k, 6);
    $display("test: wait states ended");
    ack_delay = 4'h1;
    fork
      run(1'b0, 1'b0, 2'b11, n);
      begin
        @(negedge ref_clk);
        mastership_request_n = 1'b0;
        wait_grant(1'b0);
        chk({address_valid_strobe_n, bus_oe}, 2'b01);
      end
    join
    while ({address_valid_strobe_n, transfer_ack_n} !== 2'b11) @(negedge ref_clk);
    mastership_taken_n = 1'b0;
    wait_grant(1'b1);
    repeat (2) @(negedge ref_clk);
    chk({bus_oe, bus_floated, cycle_ready}, 3'b010);
    wait_grant(1'b0);
    mastership_request_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(cycle_ready, 1'b0);
    mastership_taken_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk({bus_oe, cycle_ready}, 2'b11);
    mastership_request_n = 1'b0;
    wait_grant(1'b0);
    chk(k, 3);
    mastership_request_n = 1'b1;
    wait_grant(1'b1);
    run(1'b1, 1'b0, 2'b10, n);
    $display("test: arbitration ended");
    fault_mode = 1'b1;
    run(1'b1, 1'b0, 2'b11, n);
    halt_in_n = 1'b0;
    run(1'b0, 1'b1, 2'b10, n);
    fork
      run(1'b0, 1'b0, 2'b11, n);
      begin
        k = 0;
        // the bus is still floated from the fault before: wait for this cycle's strobe first
        while (address_valid_strobe_n !== 1'b0 && k < 60) begin
          @(negedge ref_clk);
          k++;
        end
        while (bus_floated !== 1'b1 && k < 60) begin
          @(negedge ref_clk);
          k++;
        end
        chk(bus_floated, 1'b1);
        fault_mode = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(bus_floated, 1'b1);
        halt_in_n = 1'b1;
      end
    join
    $display("test: bus faults ended");
    conclude;
  end
endmodule
`default_nettype wire
